// *** cswsel_top.sv ***
// Clock source and wait/stop behaviour control register with APB access
`timescale 1ns/1ps
`default_nettype none
`include "cswsel_regs.svh"
module cswsel_top (
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`CSWSEL_ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic                           pslverr,
  output var  logic [31:0]               prdata,
  input  wire cswsel_pkg::cswsel_status_t statusIn,
  output var  cswsel_pkg::cswsel_ctrl_t   ctrlOut,
  output var  logic [7:0]                clock_source_and_wait_control
);
  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  cswsel_pkg::cswsel_status_t st;
  cswsel_sync #(.W($bits(cswsel_pkg::cswsel_status_t))) uSync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .din      (statusIn),
    .dout     (st)
  );

  // ---------------------------------------------------------------
  // Bus front end
  // ---------------------------------------------------------------
  logic        wrCtrl;
  logic [7:0]  wrData;
  logic [31:0] rdValue;
  logic        lockSeen;
  logic        trackSeen;
  logic        wdWritten;

  assign lockSeen  = st.lock && !st.selfClock;
  assign trackSeen = st.track && !st.selfClock;

  // Status word only at its own offset; any other address shows the register
  assign rdValue = (paddr == `CSWSEL_ADDR_STATUS)
                   ? {24'h000000, 1'b0, st.waitMode, st.stopMode, st.selfClock,
                      st.autoBw, trackSeen, lockSeen, wdWritten}
                   : {24'h000000, clock_source_and_wait_control};

  cswsel_apb uApb (
    .core_clk (core_clk),
    .nrst     (nrst),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .rdValue  (rdValue),
    .pready   (pready),
    .pslverr  (pslverr),
    .prdata   (prdata),
    .wrCtrl   (wrCtrl),
    .wrData   (wrData)
  );

  // ---------------------------------------------------------------
  // Power mode tracking
  // ---------------------------------------------------------------
  cswsel_pkg::cswsel_mode_t mode;
  cswsel_pkg::cswsel_mode_t next_mode;
  logic                     waitEntry;

  always_comb
  begin
    next_mode = cswsel_pkg::CSWSEL_RUN;
    if (st.stopMode)
      next_mode = cswsel_pkg::CSWSEL_STOP;
    else if (st.waitMode)
      next_mode = cswsel_pkg::CSWSEL_WAIT;
  end

  assign waitEntry = (next_mode == cswsel_pkg::CSWSEL_WAIT) && (mode != cswsel_pkg::CSWSEL_WAIT);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic       next_wdWritten;
  logic       pllStable;

  // Auto bandwidth is forced on while PLL stop in wait is set
  assign pllStable = (st.autoBw || ctrl[`CSWSEL_BIT_PLLW]) ? lockSeen : trackSeen;

  always_comb
  begin
    next_ctrl      = ctrl;
    next_wdWritten = wdWritten;
    if (wrCtrl)
    begin
      next_ctrl[`CSWSEL_BIT_PSEUDO_STOP_SELECT]  = wrData[`CSWSEL_BIT_PSEUDO_STOP_SELECT];
      next_ctrl[`CSWSEL_BIT_SYSW]  = wrData[`CSWSEL_BIT_SYSW];
      next_ctrl[`CSWSEL_BIT_ROAW]  = wrData[`CSWSEL_BIT_ROAW];
      next_ctrl[`CSWSEL_BIT_PLLW]  = wrData[`CSWSEL_BIT_PLLW];
      next_ctrl[`CSWSEL_BIT_COREW] = wrData[`CSWSEL_BIT_COREW];
      next_ctrl[`CSWSEL_BIT_TMRW]  = wrData[`CSWSEL_BIT_TMRW];
      if (!wrData[`CSWSEL_BIT_PLL_SOURCE_SELECT] || pllStable)
        next_ctrl[`CSWSEL_BIT_PLL_SOURCE_SELECT] = wrData[`CSWSEL_BIT_PLL_SOURCE_SELECT];
      if (st.specialMode || !wdWritten)
      begin
        next_ctrl[`CSWSEL_BIT_WDW] = wrData[`CSWSEL_BIT_WDW];
        next_wdWritten             = 1'b1;
      end
    end
    // Hardware clear outranks a software set in the same cycle
    if (st.selfClock || next_mode == cswsel_pkg::CSWSEL_STOP
        || (next_mode == cswsel_pkg::CSWSEL_WAIT && ctrl[`CSWSEL_BIT_PLLW]))
      next_ctrl[`CSWSEL_BIT_PLL_SOURCE_SELECT] = 1'b0;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl      <= `CSWSEL_CTRL_RESET;
      wdWritten <= 1'b0;
      mode      <= cswsel_pkg::CSWSEL_RUN;
    end
    else
    begin
      ctrl      <= next_ctrl;
      wdWritten <= next_wdWritten;
      mode      <= next_mode;
    end
  end

  assign clock_source_and_wait_control = ctrl;

  // ---------------------------------------------------------------
  // Clock and power controls
  // ---------------------------------------------------------------
  cswsel_pkg::cswsel_ctrl_t next_ctrlOut;
  logic                     inWait;
  logic                     inStop;

  assign inWait = next_mode == cswsel_pkg::CSWSEL_WAIT;
  assign inStop = next_mode == cswsel_pkg::CSWSEL_STOP;

  always_comb
  begin
    next_ctrlOut.usePll           = next_ctrl[`CSWSEL_BIT_PLL_SOURCE_SELECT];
    next_ctrlOut.busClockHalf     = 1'b1;
    next_ctrlOut.oscEnable        = !inStop || ctrl[`CSWSEL_BIT_PSEUDO_STOP_SELECT];
    // Reduced amplitude only matters if the oscillator supports it
    next_ctrlOut.oscReducedAmp    = (inStop && ctrl[`CSWSEL_BIT_PSEUDO_STOP_SELECT])
                                    || (inWait && ctrl[`CSWSEL_BIT_ROAW]);
    next_ctrlOut.sysClockRun      = !inStop && !(inWait && ctrl[`CSWSEL_BIT_SYSW]);
    next_ctrlOut.coreClockRun     = !inStop && !(inWait && ctrl[`CSWSEL_BIT_COREW]);
    next_ctrlOut.pllPowerDown     = inWait && ctrl[`CSWSEL_BIT_PLLW];
    next_ctrlOut.forceAutoBw      = ctrl[`CSWSEL_BIT_PLLW];
    // Timer and watchdog ignore the system clock stop bit
    next_ctrlOut.timerRun         = !(inWait && ctrl[`CSWSEL_BIT_TMRW]);
    next_ctrlOut.timerDivReset    = waitEntry && ctrl[`CSWSEL_BIT_TMRW];
    next_ctrlOut.watchdogRun      = !(inWait && ctrl[`CSWSEL_BIT_WDW]);
    next_ctrlOut.watchdogDivReset = waitEntry && ctrl[`CSWSEL_BIT_WDW];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      ctrlOut <= '{usePll: 1'b0, busClockHalf: 1'b1, oscEnable: 1'b1, oscReducedAmp: 1'b0,
                   sysClockRun: 1'b1, coreClockRun: 1'b1, pllPowerDown: 1'b0, forceAutoBw: 1'b0,
                   timerRun: 1'b1, timerDivReset: 1'b0, watchdogRun: 1'b1, watchdogDivReset: 1'b0};
    else
      ctrlOut <= next_ctrlOut;
  end
endmodule // cswsel_top
`default_nettype wire

// *** cswsel_regs.svh ***
// Register offsets, bit positions and reset values of the clock select block
`ifndef CSWSEL_REGS_SVH
`define CSWSEL_REGS_SVH
`define CSWSEL_ADDR_CTRL   12'h000
`define CSWSEL_ADDR_STATUS 12'h004
`define CSWSEL_ADDR_W      12
`define CSWSEL_CTRL_RESET  8'h00
`define CSWSEL_BIT_PLL_SOURCE_SELECT  7
`define CSWSEL_BIT_PSEUDO_STOP_SELECT    6
`define CSWSEL_BIT_SYSW    5
`define CSWSEL_BIT_ROAW    4
`define CSWSEL_BIT_PLLW    3
`define CSWSEL_BIT_COREW   2
`define CSWSEL_BIT_TMRW    1
`define CSWSEL_BIT_WDW     0
`endif

// *** cswsel_pkg.sv ***
// Types shared by the clock select block
package cswsel_pkg;
  typedef struct packed {
    logic lock;
    logic track;
    logic autoBw;
    logic selfClock;
    logic stopMode;
    logic waitMode;
    logic specialMode;
  } cswsel_status_t;

  typedef struct packed {
    logic usePll;
    logic busClockHalf;
    logic oscEnable;
    logic oscReducedAmp;
    logic sysClockRun;
    logic coreClockRun;
    logic pllPowerDown;
    logic forceAutoBw;
    logic timerRun;
    logic timerDivReset;
    logic watchdogRun;
    logic watchdogDivReset;
  } cswsel_ctrl_t;

  typedef enum logic [2:0] {
    CSWSEL_RUN  = 3'b001,
    CSWSEL_WAIT = 3'b010,
    CSWSEL_STOP = 3'b100
  } cswsel_mode_t;
endpackage

// *** cswsel_sync.sv ***
// Two-flop synchroniser for status levels from the analog side
`timescale 1ns/1ps
`default_nettype none
module cswsel_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_dout;

  always_comb
  begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1 <= '0;
      dout   <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end
endmodule // cswsel_sync
`default_nettype wire

// *** cswsel_apb.sv ***
// APB slave front end: decodes one access into a write strobe and read data captured in the setup phase
`timescale 1ns/1ps
`default_nettype none
`include "cswsel_regs.svh"
module cswsel_apb (
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`CSWSEL_ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [31:0]               rdValue,
  output logic                           pready,
  output logic                           pslverr,
  output var  logic [31:0]               prdata,
  output logic                           wrCtrl,
  output logic [7:0]                     wrData
);
  logic        access;
  logic        hitCtrl;
  logic        hitStatus;
  logic [31:0] next_prdata;

  assign access    = psel && penable;
  assign hitCtrl   = paddr == `CSWSEL_ADDR_CTRL;
  assign hitStatus = paddr == `CSWSEL_ADDR_STATUS;
  assign pready    = psel;
  // Status word is read-only; writing it or an unmapped address errors
  assign pslverr   = access && !(hitCtrl || (hitStatus && !pwrite));
  assign wrCtrl    = access && pwrite && hitCtrl;
  assign wrData    = pwdata[7:0];

  always_comb
  begin
    next_prdata = prdata;
    if (psel && !penable && !pwrite)
      next_prdata = rdValue;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      prdata <= 32'h00000000;
    else
      prdata <= next_prdata;
  end
endmodule // cswsel_apb
`default_nettype wire

// *** cswsel_top_sva.sv ***
// Port checker of the clock select block
`timescale 1ns/1ps
`default_nettype none
`include "cswsel_regs.svh"
module cswsel_top_sva (
  input wire logic                       core_clk,
  input wire logic                       nrst,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [`CSWSEL_ADDR_W-1:0]  paddr,
  input wire logic [31:0]                pwdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic [31:0]                prdata,
  input wire cswsel_pkg::cswsel_status_t statusIn,
  input wire cswsel_pkg::cswsel_ctrl_t   ctrlOut,
  input wire logic [7:0]                 clock_source_and_wait_control
);
  wire logic [7:0] r = clock_source_and_wait_control;
  wire logic wrCtl = psel && penable && pwrite && paddr == 12'h000;
  logic [1:0] spQuiet, next_spQuiet;
  logic       wdDone, next_wdDone;
  // ----------------------------------------
  // Write-once tracking
  // ----------------------------------------
  // Counts only writes made well clear of special mode, so the status sync lag never misleads it
  always_comb
  begin
    next_spQuiet = statusIn.specialMode ? 2'h0 : (spQuiet == 2'h3 ? spQuiet : spQuiet + 2'h1);
    next_wdDone = wdDone || (wrCtl && spQuiet == 2'h3);
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      spQuiet <= 2'h0;
      wdDone <= 1'b0;
    end
    else
    begin
      spQuiet <= next_spQuiet;
      wdDone <= next_wdDone;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence selfClk_s; statusIn.selfClock [*4]; endsequence
  sequence waitPll_s; (statusIn.waitMode && r[3]) [*4]; endsequence
  sequence waitRise_s; $rose(statusIn.waitMode) && !statusIn.stopMode; endsequence
  a_ready_on_sel: assert property (psel |-> pready)
    else $error("no ready while selected");
  a_write_lands: assert property (wrCtl |=> r[6:1] == $past(pwdata[6:1]))
    else $error("control write lost");
  a_read_word: assert property (psel && !penable && !pwrite && paddr == 12'h000 |=> prdata == {24'h0, $past(r)})
    else $error("read data differs from register");
  a_bad_addr_err: assert property (psel && penable && paddr > 12'h004 |-> pslverr)
    else $error("unmapped access without error");
  a_wd_write_once: assert property (wrCtl && wdDone && spQuiet == 2'h3 |=> $stable(r[0]))
    else $error("watchdog bit rewritten");
  a_selfclk_clears: assert property (selfClk_s |-> !r[7])
    else $error("source select kept in self-clock");
  a_stop_clears: assert property (statusIn.stopMode [*4] |-> !r[7])
    else $error("source select kept in stop");
  a_waitpll_clears: assert property (waitPll_s |-> !r[7])
    else $error("source select kept in wait");
  a_bw_forced: assert property (r[3] [*2] |-> ctrlOut.forceAutoBw)
    else $error("auto bandwidth not forced");
  a_src_follows: assert property ((!statusIn.selfClock) [*4] ##0 $stable(r[7])
    |-> ctrlOut.usePll == r[7] && ctrlOut.busClockHalf)
    else $error("clock source differs from select");
  a_core_halt: assert property ((statusIn.waitMode && !statusIn.stopMode && r[2]) [*4] |-> !ctrlOut.coreClockRun)
    else $error("core clock runs in wait");
  // Sync lag plus the registered output puts the pulse three edges after the rise
  a_tmr_div_reset: assert property (waitRise_s ##0 r[1] |-> ##[1:4] ctrlOut.timerDivReset)
    else $error("timer dividers not reset on wait entry");
  a_wd_div_reset: assert property (waitRise_s ##0 r[0] |-> ##[1:4] ctrlOut.watchdogDivReset)
    else $error("watchdog dividers not reset on wait entry");
  a_osc_stop_off: assert property ((statusIn.stopMode && !r[6]) [*4] |-> !ctrlOut.oscEnable)
    else $error("oscillator runs in full stop");
endmodule // cswsel_top_sva
bind cswsel_top cswsel_top_sva u_sva (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .statusIn(statusIn), .ctrlOut(ctrlOut), .clock_source_and_wait_control(clock_source_and_wait_control));
`default_nettype wire

// *** tb.sv ***
// Self-checking bench of the clock select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  logic                       core_clk, nrst, psel, penable, pwrite, pslverr, pready, rerr;
  logic [11:0]                paddr;
  logic [31:0]                pwdata, prdata, rdat;
  logic [7:0]                 cswReg, m;
  cswsel_pkg::cswsel_status_t statusIn;
  cswsel_pkg::cswsel_ctrl_t   ctrlOut;
  int                         err_total, total_checks;
  bit                         wdDone;
  cswsel_top dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .statusIn(statusIn), .ctrlOut(ctrlOut),
    .clock_source_and_wait_control(cswReg));
  // ----------------------------------------
  // Bus and model tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] d);
    logic ok;
    ok = (statusIn.autoBw || m[3]) ? statusIn.lock : statusIn.track;
    apb(1'b1, 12'h000, d);
    m[6:1] = d[6:1];
    if (!wdDone || statusIn.specialMode) m[0] = d[0];
    wdDone = 1'b1;
    if (!d[7] || (ok && !statusIn.selfClock)) m[7] = d[7];
  endtask
  task automatic rd();
    apb(1'b0, 12'h000, 8'h00);
    `CHK("ctrl reg", {24'h0, m}, rdat)
    `CHK("no error", 1'b0, rerr)
    `CHK("source", {m[7], 1'b1}, {ctrlOut.usePll, ctrlOut.busClockHalf})
  endtask
  task automatic rdst();
    logic [31:0] e;
    e = {25'h0, statusIn.waitMode, statusIn.stopMode, statusIn.selfClock, statusIn.autoBw,
         statusIn.track && !statusIn.selfClock, statusIn.lock && !statusIn.selfClock, wdDone};
    apb(1'b0, 12'h004, 8'h00);
    `CHK("status", e, rdat)
  endtask
  // Waits past the two-flop status sync before the model moves
  task automatic setst(input logic [6:0] v);
    statusIn <= v;
    repeat (5) @(posedge core_clk);
    if (statusIn.stopMode || statusIn.selfClock || (statusIn.waitMode && m[3])) m[7] = 1'b0;
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (8000) @(posedge core_clk);
    err_total++;
    results();
  end
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    statusIn = '0;
    m = 8'h00;
    void'($urandom(87635));
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rd();
    apb(1'b0, 12'h010, 8'h00);
    `CHK("slave error", 1'b1, rerr)
    apb(1'b1, 12'h004, 8'hff);
    `CHK("status write error", 1'b1, rerr)
    rd();
    wr(8'h01);
    rd();
    setst(7'b0010000);
    repeat (4)
    begin
      wr(8'h80 | (8'($urandom) & 8'h76));
      rd();
    end
    setst(7'b1010000);
    wr(8'h80 | (8'($urandom) & 8'h76));
    rd();
    setst(7'b1000000);
    wr(8'h00);
    wr(8'h80);
    rd();
    setst(7'b0100000);
    rdst();
    wr(8'h80);
    rd();
    setst(7'b1010000);
    wr(8'haa);
    setst(7'b1010010);
    rd();
    `CHK("wait gates", 4'b0100, {ctrlOut.sysClockRun, ctrlOut.coreClockRun, ctrlOut.timerRun, ctrlOut.watchdogRun})
    `CHK("wait osc", 2'b10, {ctrlOut.oscEnable, ctrlOut.oscReducedAmp})
    `CHK("pll down", 2'b11, {ctrlOut.pllPowerDown, ctrlOut.forceAutoBw})
    wr(8'h16);
    rd();
    `CHK("wait gates", 4'b1000, {ctrlOut.sysClockRun, ctrlOut.coreClockRun, ctrlOut.timerRun, ctrlOut.watchdogRun})
    `CHK("wait osc", 2'b11, {ctrlOut.oscEnable, ctrlOut.oscReducedAmp})
    `CHK("pll down", 2'b00, {ctrlOut.pllPowerDown, ctrlOut.forceAutoBw})
    setst(7'b1010000);
    rd();
    wr(8'h80);
    setst(7'b1010100);
    rd();
    `CHK("stop osc", 2'b00, {ctrlOut.oscEnable, ctrlOut.oscReducedAmp})
    wr(8'h40);
    rd();
    `CHK("stop osc", 2'b11, {ctrlOut.oscEnable, ctrlOut.oscReducedAmp})
    setst(7'b1010000);
    wr(8'h80);
    setst(7'b1011000);
    rdst();
    wr(8'h80);
    rd();
    setst(7'b0000001);
    wr(8'h00);
    rd();
    results();
  end
endmodule // tb
`default_nettype wire
